// ==== sesm_pkg.sv ====
// package for the system-control event status and mask block
// assumes a 32-bit register port with a 12-bit byte address
package sesm_pkg;

  localparam int unsigned NUM_EVENTS = 7;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFS_BROWNOUT_CONTROL = 12'h030;
  localparam logic [11:0] OFS_RAW_EVENT_STATUS = 12'h050;
  localparam logic [11:0] OFS_EVENT_MASK_CONTROL = 12'h054;
  localparam logic [11:0] OFS_MASKED_STATUS = 12'h058;

  // event bit positions, shared by all three event registers
  localparam int unsigned BIT_PLL_LOCK = 6;
  localparam int unsigned BIT_CURRENT_LIMIT = 5;
  localparam int unsigned BIT_INT_OSC_FAULT = 4;
  localparam int unsigned BIT_MAIN_OSC_FAULT = 3;
  localparam int unsigned BIT_REGULATOR_UNREGULATED = 2;
  localparam int unsigned BIT_BROWNOUT = 1;
  localparam int unsigned BIT_PLL_FAULT = 0;

  // field position inside brownout_control
  localparam int unsigned BIT_BROWNOUT_RESET_SELECT = 1;

  // reset values
  localparam logic [6:0] RST_RAW_EVENT_STATUS = 7'h00;
  localparam logic [6:0] RST_EVENT_MASK_CONTROL = 7'h00;
  localparam logic RST_BROWNOUT_RESET_SELECT = 1'b0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // event inputs, one bit per source, order matches the bit positions
  typedef struct packed {
    logic pll_lock;
    logic current_limit;
    logic int_osc_fault;
    logic main_osc_fault;
    logic regulator_unregulated;
    logic brownout;
    logic pll_fault;
  } sesm_event_t;

  // register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sesm_bus_req_t;

  // whole state of the block
  typedef struct packed {
    logic [6:0] raw_event_status;
    logic [6:0] event_mask_control;
    logic brownout_reset_select;
    logic [6:0] event_prev;
    logic irq;
    logic brownout_reset;
    logic [31:0] rdata;
  } sesm_state_t;

endpackage

// ==== sesm_event_ctrl.sv ====
// system-control event latch, mask and interrupt combiner
// assumes event inputs synchronous to i_sys_clk and a single-cycle-strobe register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module sesm_event_ctrl (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // event sources
  input wire sesm_pkg::sesm_event_t i_events,
  // register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // requests to the processor and reset logic
  output logic o_irq,
  output logic o_brownout_reset
);

  sesm_pkg::sesm_state_t state_r;
  sesm_pkg::sesm_state_t state_nxt;
  sesm_pkg::sesm_bus_req_t bus_req;

  logic [6:0] ev_level;
  logic [6:0] ev_rise;
  logic [6:0] clear_req;
  logic [6:0] irq_gate;
  logic [6:0] masked_now;

  assign bus_req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign ev_level = i_events;

  // events are latched on their rising edge so a source stuck high can still be cleared
  assign ev_rise = ev_level & ~state_r.event_prev;

  assign clear_req = (bus_req.wr && bus_req.addr == sesm_pkg::OFS_MASKED_STATUS) ?
                     bus_req.wdata[6:0] : 7'h00;

  // brown-out routed to reset instead of interrupt when reset-select is set
  always_comb begin
    irq_gate = 7'h7f;
    irq_gate[sesm_pkg::BIT_BROWNOUT] = ~state_nxt.brownout_reset_select;
  end

  assign masked_now = state_r.raw_event_status & state_r.event_mask_control;

  always_comb begin
    state_nxt = state_r;
    state_nxt.event_prev = ev_level;
    // clear only touches bits that are currently masked; a new edge wins over the clear
    state_nxt.raw_event_status = (state_r.raw_event_status & ~(clear_req & state_r.event_mask_control))
                                 | ev_rise;
    // raw bits take their sets from the event edges only, never from the bus
    if (bus_req.wr && bus_req.addr == sesm_pkg::OFS_EVENT_MASK_CONTROL) begin
      state_nxt.event_mask_control = bus_req.wdata[6:0];
    end
    if (bus_req.wr && bus_req.addr == sesm_pkg::OFS_BROWNOUT_CONTROL) begin
      state_nxt.brownout_reset_select = bus_req.wdata[sesm_pkg::BIT_BROWNOUT_RESET_SELECT];
    end
    // interrupt tracks the next masked state, so it appears with the raw bit
    state_nxt.irq = |(state_nxt.raw_event_status & state_nxt.event_mask_control & irq_gate);
    state_nxt.brownout_reset = ev_rise[sesm_pkg::BIT_BROWNOUT] & state_r.brownout_reset_select;
    // read data valid only in the cycle after the strobe; reserved bits read as zero
    state_nxt.rdata = sesm_pkg::RST_RDATA;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        sesm_pkg::OFS_RAW_EVENT_STATUS: begin
          state_nxt.rdata = {25'h000_0000, state_r.raw_event_status};
        end
        sesm_pkg::OFS_EVENT_MASK_CONTROL: begin
          state_nxt.rdata = {25'h000_0000, state_r.event_mask_control};
        end
        sesm_pkg::OFS_MASKED_STATUS: begin
          state_nxt.rdata = {25'h000_0000, masked_now};
        end
        sesm_pkg::OFS_BROWNOUT_CONTROL: begin
          state_nxt.rdata = {30'h0000_0000, state_r.brownout_reset_select, 1'b0};
        end
        default: begin
          state_nxt.rdata = sesm_pkg::RST_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_r.raw_event_status <= sesm_pkg::RST_RAW_EVENT_STATUS;
      state_r.event_mask_control <= sesm_pkg::RST_EVENT_MASK_CONTROL;
      state_r.brownout_reset_select <= sesm_pkg::RST_BROWNOUT_RESET_SELECT;
      // all-ones so an input already high at release is not taken as an edge
      state_r.event_prev <= 7'h7f;
      state_r.irq <= 1'b0;
      state_r.brownout_reset <= 1'b0;
      state_r.rdata <= sesm_pkg::RST_RDATA;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_rdata = state_r.rdata;
  assign o_irq = state_r.irq;
  assign o_brownout_reset = state_r.brownout_reset;

  // checks

  default clocking cb @(posedge i_sys_clk);
  endclocking

  default disable iff (!i_rst_n);

  logic past_valid_r;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      past_valid_r <= 1'b0;
    end else begin
      past_valid_r <= 1'b1;
    end
  end

  sequence s_mask_write;
    i_wr && i_addr == sesm_pkg::OFS_EVENT_MASK_CONTROL;
  endsequence

  sequence s_clear_write;
    i_wr && i_addr == sesm_pkg::OFS_MASKED_STATUS;
  endsequence

  sequence s_read_at(logic [11:0] a);
    i_rd && i_addr == a;
  endsequence

  chk_raw_readonly: assert property (
    i_wr && i_addr == sesm_pkg::OFS_RAW_EVENT_STATUS && ev_rise == 7'h00
    |=> state_r.raw_event_status == $past(state_r.raw_event_status))
    else $error("raw status changed by a bus write");

  chk_pll_lock_set: assert property (
    ev_rise[sesm_pkg::BIT_PLL_LOCK] |=> state_r.raw_event_status[sesm_pkg::BIT_PLL_LOCK])
    else $error("pll lock edge not latched");

  chk_cur_limit_set: assert property (
    ev_rise[sesm_pkg::BIT_CURRENT_LIMIT] |=> state_r.raw_event_status[sesm_pkg::BIT_CURRENT_LIMIT])
    else $error("current limit edge not latched");

  chk_int_osc_set: assert property (
    ev_rise[sesm_pkg::BIT_INT_OSC_FAULT] |=> state_r.raw_event_status[sesm_pkg::BIT_INT_OSC_FAULT])
    else $error("internal oscillator fault not latched");

  chk_main_osc_set: assert property (
    ev_rise[sesm_pkg::BIT_MAIN_OSC_FAULT] |=> state_r.raw_event_status[sesm_pkg::BIT_MAIN_OSC_FAULT])
    else $error("main oscillator fault not latched");

  chk_regulator_set: assert property (
    ev_rise[sesm_pkg::BIT_REGULATOR_UNREGULATED]
    |=> state_r.raw_event_status[sesm_pkg::BIT_REGULATOR_UNREGULATED])
    else $error("regulator unregulated event not latched");

  chk_brownout_gate: assert property (
    state_r.brownout_reset_select && state_r.raw_event_status == 7'h02 |-> !o_irq)
    else $error("brown-out interrupt while reset-select set");

  chk_pll_fault_set: assert property (
    ev_rise[sesm_pkg::BIT_PLL_FAULT] |=> state_r.raw_event_status[sesm_pkg::BIT_PLL_FAULT])
    else $error("pll fault not latched");

  chk_mask_write: assert property (
    s_mask_write |=> state_r.event_mask_control == $past(i_wdata[6:0]))
    else $error("mask write not taken");

  chk_mask_readback: assert property (
    s_read_at(sesm_pkg::OFS_EVENT_MASK_CONTROL) |=> o_rdata == {25'h000_0000, $past(state_r.event_mask_control)})
    else $error("mask readback mismatch");

  chk_no_raw_no_irq: assert property (
    (state_r.raw_event_status & state_r.event_mask_control) == 7'h00 |-> !o_irq)
    else $error("interrupt without a masked event");

  chk_mask_reset: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    !i_rst_n |=> state_r.event_mask_control == 7'h00 && !o_irq)
    else $error("mask not zero after reset");

  chk_irq_or: assert property (
    past_valid_r |-> o_irq == |(state_r.raw_event_status & state_r.event_mask_control & {5'h1f,
      ~state_r.brownout_reset_select, 1'b1}))
    else $error("interrupt differs from masked status");

  chk_w1c_clear: assert property (
    s_clear_write ##0 (ev_rise == 7'h00)
    |=> (state_r.raw_event_status & $past(i_wdata[6:0] & state_r.event_mask_control)) == 7'h00)
    else $error("write one did not clear masked bit");

  chk_w0_keeps: assert property (
    s_clear_write |=> (state_r.raw_event_status & ~$past(i_wdata[6:0] & state_r.event_mask_control))
    == ($past(state_r.raw_event_status) & ~$past(i_wdata[6:0] & state_r.event_mask_control)))
    else $error("clear write disturbed other bits");

  chk_set_wins: assert property (
    s_clear_write ##0 (ev_rise != 7'h00) |=> (state_r.raw_event_status & $past(ev_rise)) == $past(ev_rise))
    else $error("event lost to a same-cycle clear");

  chk_bor_reset: assert property (
    ev_rise[sesm_pkg::BIT_BROWNOUT] && state_r.brownout_reset_select |=> o_brownout_reset ##1 !o_brownout_reset
    || ev_rise[sesm_pkg::BIT_BROWNOUT])
    else $error("brown-out reset request missing");

  chk_no_bor_reset: assert property (
    !state_r.brownout_reset_select |=> !o_brownout_reset)
    else $error("brown-out reset without reset-select");

  chk_irq_holds: assert property (
    o_irq && !i_wr |=> o_irq)
    else $error("interrupt dropped while masked bit set");

  chk_read_latency: assert property (
    s_read_at(sesm_pkg::OFS_RAW_EVENT_STATUS) |=> o_rdata == {25'h000_0000, $past(state_r.raw_event_status)})
    else $error("raw status read data wrong");

  chk_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data present without a read");

  // register readback paths
  chk_masked_read: assert property (
    s_read_at(sesm_pkg::OFS_MASKED_STATUS) |=> o_rdata == {25'h000_0000, $past(masked_now)})
    else $error("masked status read data wrong");

  chk_bctl_read: assert property (
    s_read_at(sesm_pkg::OFS_BROWNOUT_CONTROL) |=> o_rdata == {30'h0000_0000, $past(state_r.brownout_reset_select), 1'b0})
    else $error("brown-out control read data wrong");

  chk_unmapped_read: assert property (
    i_rd && i_addr != sesm_pkg::OFS_RAW_EVENT_STATUS && i_addr != sesm_pkg::OFS_EVENT_MASK_CONTROL
    && i_addr != sesm_pkg::OFS_MASKED_STATUS && i_addr != sesm_pkg::OFS_BROWNOUT_CONTROL |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // raw bits move only on an event edge or a write-one clear
  chk_raw_set_cause: assert property (
    past_valid_r |-> (state_r.raw_event_status & ~$past(state_r.raw_event_status) & ~$past(ev_rise)) == 7'h00)
    else $error("raw bit set without an event edge");

  chk_raw_clear_cause: assert property (
    past_valid_r |-> ($past(state_r.raw_event_status) & ~state_r.raw_event_status
    & ~$past(clear_req & state_r.event_mask_control)) == 7'h00)
    else $error("raw bit cleared without a masked clear");

  // control bits move only on their own writes
  chk_mask_stable: assert property (
    !(i_wr && i_addr == sesm_pkg::OFS_EVENT_MASK_CONTROL) |=> $stable(state_r.event_mask_control))
    else $error("mask changed without a mask write");

  chk_bsel_stable: assert property (
    !(i_wr && i_addr == sesm_pkg::OFS_BROWNOUT_CONTROL) |=> $stable(state_r.brownout_reset_select))
    else $error("reset-select changed without a write");

  chk_bsel_write: assert property (
    i_wr && i_addr == sesm_pkg::OFS_BROWNOUT_CONTROL
    |=> state_r.brownout_reset_select == $past(i_wdata[sesm_pkg::BIT_BROWNOUT_RESET_SELECT]))
    else $error("reset-select write not taken");

  // brown-out routing
  chk_bor_raw_sel: assert property (
    ev_rise[sesm_pkg::BIT_BROWNOUT] && state_r.brownout_reset_select |=> state_r.raw_event_status[sesm_pkg::BIT_BROWNOUT])
    else $error("brown-out raw bit not set under reset-select");

  chk_bor_single: assert property (
    o_brownout_reset |=> !o_brownout_reset)
    else $error("brown-out reset request longer than one cycle");

  chk_bor_cause: assert property (
    o_brownout_reset |-> $past(ev_rise[sesm_pkg::BIT_BROWNOUT]))
    else $error("brown-out reset request without a brown-out edge");

  chk_irq_bor_on: assert property (
    !state_r.brownout_reset_select && state_r.raw_event_status[1] && state_r.event_mask_control[1] |-> o_irq)
    else $error("brown-out interrupt missing");

  // interrupt level, reserved read bits and reset state
  chk_irq_any: assert property (
    (state_r.raw_event_status & state_r.event_mask_control & 7'h7d) != 7'h00 |-> o_irq)
    else $error("interrupt low with a masked event set");

  chk_irq_rise_cause: assert property (
    past_valid_r && $rose(o_irq) |-> $past(ev_rise) != 7'h00 || $past(i_wr))
    else $error("interrupt rose without event or write");

  chk_irq_fall_cause: assert property (
    past_valid_r && $fell(o_irq) |-> $past(i_wr))
    else $error("interrupt fell without a write");

  chk_mask_zero_irq: assert property (
    s_mask_write ##0 (i_wdata[6:0] == 7'h00) |=> !o_irq)
    else $error("interrupt with all masks clear");

  chk_w1c_irq_drop: assert property (
    s_clear_write ##0 ((masked_now & ~i_wdata[6:0]) == 7'h00 && ev_rise == 7'h00) |=> !o_irq)
    else $error("interrupt stayed after clearing all masked bits");

  chk_rdata_reserved: assert property (
    o_rdata[31:7] == 25'h000_0000)
    else $error("reserved read bits not zero");

  chk_reset_outputs: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    !i_rst_n |=> o_rdata == 32'h0000_0000 && !o_brownout_reset && state_r.raw_event_status == 7'h00
    && !state_r.brownout_reset_select)
    else $error("state not cleared by reset");

  // per-bit clear and promote behaviour; bit 1 also depends on reset-select
  for (genvar k = 0; k < sesm_pkg::NUM_EVENTS; k++) begin : g_bit_chk
    chk_bit_w1c: assert property (
      s_clear_write ##0 (i_wdata[k] && state_r.event_mask_control[k] && !ev_rise[k]) |=> !state_r.raw_event_status[k])
      else $error("masked bit not cleared by write one");

    chk_bit_keep: assert property (
      s_clear_write ##0 (state_r.raw_event_status[k] && !state_r.event_mask_control[k]) |=> state_r.raw_event_status[k])
      else $error("unmasked raw bit cleared");

    chk_bit_promote: assert property (
      ev_rise[k] && state_r.event_mask_control[k] && !i_wr
      && (k != sesm_pkg::BIT_BROWNOUT || !state_r.brownout_reset_select) |=> o_irq)
      else $error("masked event did not raise the interrupt");

    chk_bit_hold: assert property (
      state_r.raw_event_status[k] && !(i_wr && i_addr == sesm_pkg::OFS_MASKED_STATUS) |=> state_r.raw_event_status[k])
      else $error("raw bit dropped without a clear");
  end

endmodule

// ==== sesm_event_src.sv ====
// event source model: turns one-cycle fire requests into event levels
// assumes the bench drives i_fire just after the rising clock edge
`timescale 1ns/10ps
module sesm_event_src (
  // clock
  input wire logic i_sys_clk,
  // requests from the bench
  input wire logic [6:0] i_fire,
  // event levels to the block
  output sesm_pkg::sesm_event_t o_events
);
  // registered, so a level moves just after an edge like a real source
  always @(posedge i_sys_clk) begin
    o_events <= i_fire;
  end
endmodule

// ==== sesm_event_ctrl_bench.sv ====
// self-checking bench for the event status, mask and interrupt block
// assumes a 200 MHz clock and a synchronous active-low reset
`timescale 1ns/10ps
module sesm_event_ctrl_bench;
  logic i_sys_clk, i_rst_n, i_wr, i_rd, o_irq, o_brownout_reset;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [6:0] fire_r;
  sesm_pkg::sesm_event_t i_events;
  int failures, checks, pulses;

  sesm_event_src i_sesm_event_src (.i_sys_clk(i_sys_clk), .i_fire(fire_r), .o_events(i_events));
  sesm_event_ctrl i_sesm_event_ctrl (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_events(i_events),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_brownout_reset(o_brownout_reset));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    if (o_brownout_reset === 1'b1) pulses++;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // only bits 6:0 are ever written, reserved bits are left alone
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v & 32'h0000_007f;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  task automatic fire(input logic [6:0] b);
    @(posedge i_sys_clk);
    fire_r <= b;
    @(posedge i_sys_clk);
    fire_r <= 7'h00;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic t_reset();
    logic [11:0] a[5];
    a = '{sesm_pkg::OFS_RAW_EVENT_STATUS, sesm_pkg::OFS_EVENT_MASK_CONTROL, sesm_pkg::OFS_MASKED_STATUS,
      sesm_pkg::OFS_BROWNOUT_CONTROL, 12'h100};
    chk("irq", o_irq, 1'b0);
    foreach (a[k]) begin
      rd(a[k], d);
      chk("reset read", d, 32'h0000_0000);
    end
  endtask

  task automatic t_each();
    logic [31:0] b;
    for (int i = 0; i < 7; i++) begin
      b = 32'h0000_0001 << i;
      wr(sesm_pkg::OFS_EVENT_MASK_CONTROL, b);
      fire(b[6:0]);
      chk("irq set", o_irq, 1'b1);
      rd(sesm_pkg::OFS_RAW_EVENT_STATUS, d);
      chk("raw", d, b);
      wr(sesm_pkg::OFS_RAW_EVENT_STATUS, 32'h0000_007f);
      rd(sesm_pkg::OFS_RAW_EVENT_STATUS, d);
      chk("raw after write", d, b);
      rd(sesm_pkg::OFS_MASKED_STATUS, d);
      chk("masked", d, b);
      wr(sesm_pkg::OFS_MASKED_STATUS, b);
      #1 chk("irq clear", o_irq, 1'b0);
      rd(sesm_pkg::OFS_RAW_EVENT_STATUS, d);
      chk("raw cleared", d, 32'h0000_0000);
    end
  endtask

  task automatic t_mask();
    wr(sesm_pkg::OFS_EVENT_MASK_CONTROL, 32'h0000_0000);
    fire(7'h7f);
    chk("irq masked", o_irq, 1'b0);
    rd(sesm_pkg::OFS_MASKED_STATUS, d);
    chk("masked none", d, 32'h0000_0000);
    wr(sesm_pkg::OFS_MASKED_STATUS, 32'h0000_007f);
    wr(sesm_pkg::OFS_EVENT_MASK_CONTROL, 32'h0000_007f);
    #1 chk("irq all", o_irq, 1'b1);
    rd(sesm_pkg::OFS_EVENT_MASK_CONTROL, d);
    chk("mask rw", d, 32'h0000_007f);
    wr(sesm_pkg::OFS_MASKED_STATUS, 32'h0000_0000);
    rd(sesm_pkg::OFS_RAW_EVENT_STATUS, d);
    chk("zero write", d, 32'h0000_007f);
    wr(sesm_pkg::OFS_MASKED_STATUS, 32'h0000_007e);
    #1 chk("irq one left", o_irq, 1'b1);
    rd(sesm_pkg::OFS_RAW_EVENT_STATUS, d);
    chk("partial clear", d, 32'h0000_0001);
    wr(sesm_pkg::OFS_MASKED_STATUS, 32'h0000_0001);
    #1 chk("irq none", o_irq, 1'b0);
  endtask

  task automatic t_brownout();
    wr(sesm_pkg::OFS_BROWNOUT_CONTROL, 32'h0000_0002);
    wr(sesm_pkg::OFS_EVENT_MASK_CONTROL, 32'h0000_0002);
    pulses = 0;
    fire(7'h02);
    chk("reset pulses", pulses, 32'h0000_0001);
    chk("irq gated", o_irq, 1'b0);
    rd(sesm_pkg::OFS_RAW_EVENT_STATUS, d);
    chk("brownout raw", d, 32'h0000_0002);
    rd(sesm_pkg::OFS_BROWNOUT_CONTROL, d);
    chk("reset select", d, 32'h0000_0002);
    rd(sesm_pkg::OFS_MASKED_STATUS, d);
    chk("masked brownout", d, 32'h0000_0002);
    wr(sesm_pkg::OFS_BROWNOUT_CONTROL, 32'h0000_0000);
    #1 chk("irq ungated", o_irq, 1'b1);
    wr(sesm_pkg::OFS_MASKED_STATUS, 32'h0000_0002);
    #1 chk("irq off", o_irq, 1'b0);
    wr(sesm_pkg::OFS_EVENT_MASK_CONTROL, 32'h0000_007f);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(sesm_pkg::OFS_EVENT_MASK_CONTROL, d);
    chk("mask after reset", d, 32'h0000_0000);
  endtask

  // a new edge lands in the same cycle as a clear of that bit: the set must win
  task automatic t_set_wins();
    wr(sesm_pkg::OFS_EVENT_MASK_CONTROL, 32'h0000_0001);
    fire(7'h01);
    @(posedge i_sys_clk);
    fire_r <= 7'h01;
    @(posedge i_sys_clk);
    fire_r <= 7'h00;
    i_wr <= 1'b1;
    i_addr <= sesm_pkg::OFS_MASKED_STATUS;
    i_wdata <= 32'h0000_0001;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1 chk("irq set wins", o_irq, 1'b1);
    rd(sesm_pkg::OFS_RAW_EVENT_STATUS, d);
    chk("raw set wins", d, 32'h0000_0001);
    wr(sesm_pkg::OFS_MASKED_STATUS, 32'h0000_0001);
    #1 chk("irq after clear", o_irq, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // whole run is well under 2000 cycles
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end

  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata, fire_r} = '0;
    failures = 0;
    checks = 0;
    pulses = 0;
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_each();
    t_mask();
    t_set_wins();
    t_brownout();
    tally_and_finish();
  end
endmodule
